// ==== bsdp_top.sv ====
// Boot select, reset state control and dual data pointer register bank
//
// Contract
// - Boot region: select 0 application, 1 loader
// - Non-software resets load inverted configuration boot bit
// - Restart region decided from select register bit
// - RAM kept except after power-on reset
// - Program counter held at 0000H during reset
// - Stack pointer set to 07H every reset
// - Peripherals and interrupts disabled after reset
// - Port latches FFH, pins input-only after reset
// - Two pointers, auxiliary bit 0 selects one
// - Inactive pointer keeps its value
// - Auxiliary bit 1 reads zero always
// - Auxiliary bit 3 is free user flag
// - Pointer byte registers present active pointer
// - Pointer bytes at 82H, 83H reset zero
// - Chip control bit 7 triggers software reset
// - Chip control writable only after unlock sequence
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module bsdp_top
  import bsdp_pkg::*;
#(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // Reset sources
  input  wire logic             por_i,
  input  wire logic             hw_rst_i,
  input  wire logic [7:0]       boot_cfg_i,
  // Avalon-MM slave
  input  wire logic [9:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  // Core state
  output logic                  core_rst_o,
  output logic                  boot_loader_o,
  output logic      [15:0]      pc_force_o,
  output logic                  sp_load_o,
  output logic      [7:0]       sp_value_o,
  output logic                  periph_off_o,
  output logic                  port_init_o,
  output logic      [7:0]       port_latch_o,
  output logic                  ram_retained_o,
  output logic                  iap_en_o,
  output logic      [PTR_W-1:0] data_ptr_o
);

  // Bus decode: the index is the word address
  function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
    hit = (addr[9:2] == idx);
  endfunction

  bsdp_rst_state_e  state_ff;
  bsdp_rst_state_e  nxt_state;
  logic [CNT_W-1:0] soft_cnt_ff;
  logic [CNT_W-1:0] guard_cnt_ff;
  logic             guard_armed_ff;
  logic             wait_ff;
  logic [31:0]      rdata_ff;
  logic             boot_sel_ff;
  logic             iap_en_ff;
  logic             soft_req_ff;
  logic             psel_ff;
  logic             flag2_ff;
  logic             boot_ff;
  logic             in_rst_ff;
  logic             ram_ok_ff;
  logic             cfg_done_ff;
  logic             cold_ff;
  logic [PTR_W-1:0] data_ptr_ff;
  logic [15:0]      pc_ff;
  logic [7:0]       sp_ff;
  logic [7:0]       port_ff;
  logic [PTR_W-1:0] ptr_act;
  logic             req;
  logic             wr_go;
  logic             rd_go;
  logic [7:0]       wbyte;
  logic             in_reset;
  logic             guard_open;

  assign req      = avs_read | avs_write;
  assign wr_go    = avs_write & ~wait_ff & avs_byteenable[0];
  assign rd_go    = avs_read & wait_ff;
  assign wbyte    = avs_writedata[7:0];
  assign in_reset = (state_ff != BSDP_RUN);
  assign guard_open = (guard_cnt_ff != '0);

  // Reset sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      BSDP_RUN: begin
        if (hw_rst_i || por_i) begin
          nxt_state = BSDP_HOLD;
        end else if (soft_req_ff) begin
          nxt_state = BSDP_SOFT;
        end
      end
      BSDP_SOFT: begin
        if (hw_rst_i || por_i) begin
          nxt_state = BSDP_HOLD;
        end else if (soft_cnt_ff == CNT_W'(SOFT_RST_CYC - 1)) begin
          nxt_state = BSDP_RUN;
        end
      end
      BSDP_HOLD: begin
        if (!hw_rst_i && !por_i && cfg_done_ff) begin
          nxt_state = BSDP_RUN;
        end
      end
      default: begin
        nxt_state = BSDP_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= BSDP_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_cnt_ff <= '0;
    end else if (state_ff == BSDP_SOFT) begin
      soft_cnt_ff <= soft_cnt_ff + CNT_W'(1);
    end else begin
      soft_cnt_ff <= '0;
    end
  end

  // Hold lasts one edge past the boot select load, so the restart region sees the loaded bit
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_done_ff <= 1'b0;
    end else begin
      cfg_done_ff <= (state_ff == BSDP_HOLD);
    end
  end

  // Avalon handshake: one wait cycle, then the answer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_ff <= 1'b1;
    end else if (req && wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // Read data, registered in the wait cycle; unmapped reads return zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else if (rd_go) begin
      rdata_ff <= '0;
      if (hit(avs_address, IDX_PTR_LO)) begin
        rdata_ff[7:0] <= ptr_act[7:0];
      end else if (hit(avs_address, IDX_PTR_HI)) begin
        rdata_ff[7:0] <= ptr_act[PTR_W-1:8];
      end else if (hit(avs_address, IDX_CHIP_CTL)) begin
        rdata_ff[CHP_BOOT_SEL_BIT] <= boot_sel_ff;
        rdata_ff[CHP_IAP_EN_BIT]   <= iap_en_ff;
      end else if (hit(avs_address, IDX_AUX_CTL)) begin
        rdata_ff[AUX_FLAG2_BIT] <= flag2_ff;
        rdata_ff[AUX_ZERO_BIT]  <= 1'b0;
        rdata_ff[AUX_PSEL_BIT]  <= psel_ff;
      end
    end
  end

  // Timed access guard: first key arms, second key opens a short window
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_armed_ff <= 1'b0;
    end else if (in_reset) begin
      guard_armed_ff <= 1'b0;
    end else if (wr_go && hit(avs_address, IDX_GUARD)) begin
      guard_armed_ff <= (wbyte == GUARD_KEY_FIRST);
    end else if (wr_go) begin
      guard_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      guard_cnt_ff <= '0;
    end else if (in_reset) begin
      guard_cnt_ff <= '0;
    end else if (wr_go && hit(avs_address, IDX_GUARD) && guard_armed_ff && wbyte == GUARD_KEY_SECOND) begin
      guard_cnt_ff <= CNT_W'(GUARD_WIN_CYC);
    end else if (wr_go && hit(avs_address, IDX_CHIP_CTL)) begin
      guard_cnt_ff <= '0;
    end else if (guard_open) begin
      guard_cnt_ff <= guard_cnt_ff - CNT_W'(1);
    end
  end

  // Chip control: boot select, in-application programming enable, soft reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_sel_ff <= BOOT_SEL_RST;
    end else if (state_ff == BSDP_HOLD) begin
      boot_sel_ff <= ~boot_cfg_i[CFG_BOOT_SRC_BIT];
    end else if (state_ff == BSDP_RUN && wr_go && hit(avs_address, IDX_CHIP_CTL) && guard_open) begin
      boot_sel_ff <= wbyte[CHP_BOOT_SEL_BIT];
    end
    // Kept through a software reset
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iap_en_ff <= FLAG_RST;
    end else if (in_reset) begin
      iap_en_ff <= FLAG_RST;
    end else if (wr_go && hit(avs_address, IDX_CHIP_CTL) && guard_open) begin
      iap_en_ff <= wbyte[CHP_IAP_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_req_ff <= 1'b0;
    end else if (in_reset) begin
      soft_req_ff <= 1'b0;
    end else if (wr_go && hit(avs_address, IDX_CHIP_CTL) && guard_open && wbyte[CHP_SOFT_RST_BIT]) begin
      soft_req_ff <= 1'b1;
    end
  end

  // Auxiliary control: pointer select and user flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      psel_ff  <= FLAG_RST;
      flag2_ff <= FLAG_RST;
    end else if (in_reset) begin
      psel_ff  <= FLAG_RST;
      flag2_ff <= FLAG_RST;
    end else if (wr_go && hit(avs_address, IDX_AUX_CTL)) begin
      psel_ff  <= wbyte[AUX_PSEL_BIT];
      flag2_ff <= wbyte[AUX_FLAG2_BIT];
    end
  end

  bsdp_ptr_pair #(
    .PTR_W    (PTR_W)
  ) u_ptr (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .init_i   (in_reset),
    .sel_i    (psel_ff),
    .wr_lo_i  (wr_go && hit(avs_address, IDX_PTR_LO)),
    .wr_hi_i  (wr_go && hit(avs_address, IDX_PTR_HI)),
    .wdata_i  (wbyte),
    .active_o (ptr_act)
  );

  // Restart region is taken from the select register when reset ends
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_ff <= BOOT_SEL_RST;
    end else if (in_reset) begin
      boot_ff <= boot_sel_ff;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_rst_ff <= 1'b1;
    end else begin
      in_rst_ff <= (nxt_state != BSDP_RUN);
    end
  end

  // A cold start lasts until the core runs again; only later resets keep RAM
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cold_ff <= 1'b1;
    end else if (por_i) begin
      cold_ff <= 1'b1;
    end else if (!in_reset) begin
      cold_ff <= 1'b0;
    end
  end

  // Active pointer registered so the output comes from a flop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_ptr_ff <= PTR_W'({PTR_RST_VAL, PTR_RST_VAL});
    end else begin
      data_ptr_ff <= ptr_act;
    end
  end

  // Restart values for the core, held in flops like every other output
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_ff   <= PC_RST_VAL;
      sp_ff   <= SP_RST_VAL;
      port_ff <= PORT_RST_VAL;
    end else begin
      pc_ff   <= PC_RST_VAL;
      sp_ff   <= SP_RST_VAL;
      port_ff <= PORT_RST_VAL;
    end
  end

  // RAM is only undefined after a power-on reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_ok_ff <= 1'b0;
    end else if (por_i) begin
      ram_ok_ff <= 1'b0;
    end else if (in_reset && !cold_ff) begin
      ram_ok_ff <= 1'b1;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign core_rst_o      = in_rst_ff;
  assign boot_loader_o   = boot_ff;
  assign pc_force_o      = pc_ff;
  assign sp_load_o       = in_rst_ff;
  assign sp_value_o      = sp_ff;
  assign periph_off_o    = in_rst_ff;
  assign port_init_o     = in_rst_ff;
  assign port_latch_o    = port_ff;
  assign ram_retained_o  = ram_ok_ff;
  assign iap_en_o        = iap_en_ff;
  assign data_ptr_o      = data_ptr_ff;

endmodule // bsdp_top

// ==== bsdp_pkg.sv ====
// Constants for the boot select and dual data pointer register bank
package bsdp_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_PTR_LO   = 8'h82;
  localparam logic [7:0] IDX_PTR_HI   = 8'h83;
  localparam logic [7:0] IDX_CHIP_CTL = 8'h9F;
  localparam logic [7:0] IDX_AUX_CTL  = 8'hA2;
  localparam logic [7:0] IDX_GUARD    = 8'hC7;

  // Field positions
  localparam int CHP_SOFT_RST_BIT = 7;
  localparam int CHP_BOOT_SEL_BIT = 1;
  localparam int CHP_IAP_EN_BIT   = 0;
  localparam int AUX_FLAG2_BIT    = 3;
  localparam int AUX_ZERO_BIT     = 1;
  localparam int AUX_PSEL_BIT     = 0;
  localparam int CFG_BOOT_SRC_BIT = 7;

  // Reset values
  localparam logic [7:0]  PTR_RST_VAL   = 8'h00;
  localparam logic [15:0] PC_RST_VAL    = 16'h0000;
  localparam logic [7:0]  SP_RST_VAL    = 8'h07;
  localparam logic [7:0]  PORT_RST_VAL  = 8'hFF;
  localparam logic        BOOT_SEL_RST  = 1'b0;
  localparam logic        FLAG_RST      = 1'b0;

  // Timed access unlock keys
  localparam logic [7:0] GUARD_KEY_FIRST  = 8'hAA;
  localparam logic [7:0] GUARD_KEY_SECOND = 8'h55;

  // Timing counts in system clock cycles
  localparam int CLK_PERIOD_NS   = 5;
  localparam int GUARD_WIN_NS    = 40;
  localparam int GUARD_WIN_CYC   = (GUARD_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_RST_NS     = 40;
  localparam int SOFT_RST_CYC    = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;

  // Reset sequencer states, Gray order RUN -> SOFT -> HOLD
  typedef enum logic [1:0] {
    BSDP_RUN  = 2'b00,
    BSDP_SOFT = 2'b01,
    BSDP_HOLD = 2'b11
  } bsdp_rst_state_e;

endpackage

// ==== bsdp_ptr_pair.sv ====
// Two independent 16-bit data pointers with byte access steered by the select bit
`timescale 1ns/1ps
module bsdp_ptr_pair
  import bsdp_pkg::*;
#(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             init_i,
  // Access
  input  wire logic             sel_i,
  input  wire logic             wr_lo_i,
  input  wire logic             wr_hi_i,
  input  wire logic [7:0]       wdata_i,
  output logic      [PTR_W-1:0] active_o
);

  logic [PTR_W-1:0] ptr_ff [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ptr
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ptr_ff[g] <= PTR_W'({PTR_RST_VAL, PTR_RST_VAL});
        end else if (init_i) begin
          ptr_ff[g] <= PTR_W'({PTR_RST_VAL, PTR_RST_VAL});
        end else if (sel_i == 1'(g)) begin
          if (wr_lo_i) begin
            ptr_ff[g][7:0] <= wdata_i;
          end
          if (wr_hi_i) begin
            ptr_ff[g][PTR_W-1:8] <= wdata_i;
          end
        end
        // The unselected pointer holds its value
      end
    end
  endgenerate

  assign active_o = ptr_ff[sel_i];

endmodule // bsdp_ptr_pair

// ==== bsdp_chk_monitor.sv ====
// Concurrent checks on the boot select and dual pointer register bank ports
`timescale 1ns/1ps
module bsdp_chk
  import bsdp_pkg::*;
#(
  parameter int PTR_W = 16
) (
  // Clock and reset
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  // Reset sources
  input wire logic             por_i,
  input wire logic             hw_rst_i,
  input wire logic [7:0]       boot_cfg_i,
  // Avalon-MM slave
  input wire logic [9:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_writedata,
  input wire logic [3:0]       avs_byteenable,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // Core state
  input wire logic             core_rst_o,
  input wire logic             boot_loader_o,
  input wire logic [15:0]      pc_force_o,
  input wire logic             sp_load_o,
  input wire logic [7:0]       sp_value_o,
  input wire logic             periph_off_o,
  input wire logic             port_init_o,
  input wire logic [7:0]       port_latch_o,
  input wire logic             ram_retained_o,
  input wire logic             iap_en_o,
  input wire logic [PTR_W-1:0] data_ptr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence soft_entry;
    $rose(core_rst_o) && !por_i && !hw_rst_i;
  endsequence

  a_pc_held_zero: assert property (core_rst_o |-> pc_force_o == 16'h0000)
    else $error("program counter not forced to zero in reset");
  a_sp_reset_val: assert property (core_rst_o |-> sp_load_o && sp_value_o == 8'h07)
    else $error("stack pointer not loaded with 07 in reset");
  a_periph_kept_off: assert property (core_rst_o |-> periph_off_o)
    else $error("peripherals not held off in reset");
  a_port_latch_init: assert property (core_rst_o |-> port_init_o && port_latch_o == 8'hFF)
    else $error("port latches not set to FF in reset");
  a_soft_rst_len: assert property (soft_entry |-> core_rst_o [*8] ##1 !core_rst_o)
    else $error("soft reset length wrong");
  a_boot_sel_steady: assert property (!core_rst_o ##1 !core_rst_o |-> $stable(boot_loader_o))
    else $error("boot region changed outside reset");
  a_aux_bit_zero: assert property ((avs_read && !avs_waitrequest && avs_address[9:2] == IDX_AUX_CTL)
    |-> avs_readdata[1] == 1'b0 && avs_readdata[31:4] == 28'h0000000)
    else $error("auxiliary hard zero bit read as one");
  a_read_answer: assert property ((avs_read && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("read not answered in one cycle");
  a_ptr_read_steer: assert property ((avs_read && !avs_waitrequest && avs_address[9:2] == IDX_PTR_LO)
    |-> avs_readdata[7:0] == data_ptr_o[7:0])
    else $error("pointer low byte read not from active pointer");

  c_soft_reset: cover property (soft_entry);
  c_aux_read: cover property (avs_read && !avs_waitrequest && avs_address[9:2] == IDX_AUX_CTL);
  c_iap_on: cover property ($rose(iap_en_o));
endmodule // bsdp_chk

bind bsdp_top bsdp_chk #(.PTR_W(PTR_W)) bsdp_chk_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_i(por_i), .hw_rst_i(hw_rst_i), .boot_cfg_i(boot_cfg_i),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .core_rst_o(core_rst_o), .boot_loader_o(boot_loader_o), .pc_force_o(pc_force_o), .sp_load_o(sp_load_o),
  .sp_value_o(sp_value_o), .periph_off_o(periph_off_o), .port_init_o(port_init_o),
  .port_latch_o(port_latch_o), .ram_retained_o(ram_retained_o), .iap_en_o(iap_en_o),
  .data_ptr_o(data_ptr_o));

// ==== bsdp_tb.sv ====
// Self-checking testbench for the boot select and dual pointer register bank
`timescale 1ns/1ps
module tb_top
  import bsdp_pkg::*;
;
  logic        mclk_i, rst_n_i, por_i, hw_rst_i;
  logic [7:0]  boot_cfg_i;
  logic [9:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        core_rst_o, boot_loader_o, iap_en_o, ram_retained_o;
  logic [15:0] data_ptr_o;
  int          mismatches = 0;
  int          n_tests = 0;

  bsdp_top #(.PTR_W(16)) bsdp_top_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .por_i(por_i), .hw_rst_i(hw_rst_i), .boot_cfg_i(boot_cfg_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .core_rst_o(core_rst_o), .boot_loader_o(boot_loader_o), .pc_force_o(), .sp_load_o(), .sp_value_o(),
    .periph_off_o(), .port_init_o(), .port_latch_o(), .ram_retained_o(ram_retained_o),
    .iap_en_o(iap_en_o), .data_ptr_o(data_ptr_o));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic close_out;
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      close_out();
    end
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, exp);
  endtask

  // Waits for core reset to reach the given level
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core_rst_o !== lvl && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      close_out();
    end
    @(posedge mclk_i);
  endtask

  task automatic unlock;
    wr(IDX_GUARD, GUARD_KEY_FIRST);
    wr(IDX_GUARD, GUARD_KEY_SECOND);
  endtask

  task automatic t_reset_vals;
    chk(boot_loader_o, 1'b0);
    chk(ram_retained_o, 1'b0);
    chk(data_ptr_o, 16'h0000);
    rd(IDX_PTR_LO, 32'h00000000);
    rd(IDX_PTR_HI, 32'h00000000);
    rd(IDX_AUX_CTL, 32'h00000000);
  endtask

  task automatic t_pointers;
    wr(IDX_PTR_LO, 8'h34);
    wr(IDX_PTR_HI, 8'h12);
    @(posedge mclk_i);
    chk(data_ptr_o, 16'h1234);
    wr(IDX_AUX_CTL, 8'hFF);
    rd(IDX_AUX_CTL, 32'h00000009);
    chk(data_ptr_o, 16'h0000);
    wr(IDX_PTR_LO, 8'hCD);
    wr(IDX_PTR_HI, 8'hAB);
    rd(IDX_PTR_LO, 32'h000000CD);
    wr(IDX_AUX_CTL, 8'h08);
    rd(IDX_AUX_CTL, 32'h00000008);
    chk(data_ptr_o, 16'h1234);
    rd(IDX_PTR_HI, 32'h00000012);
    wr(IDX_AUX_CTL, 8'h09);
    @(posedge mclk_i);
    chk(data_ptr_o, 16'hABCD);
    wr(IDX_AUX_CTL, 8'h0A);
    rd(IDX_AUX_CTL, 32'h00000008);
    avs_byteenable <= 4'hE;
    wr(IDX_PTR_LO, 8'h77);
    avs_byteenable <= 4'hF;
    rd(IDX_PTR_LO, 32'h00000034);
  endtask

  task automatic t_chip_ctl;
    wr(IDX_CHIP_CTL, 8'h03);
    rd(IDX_CHIP_CTL, 32'h00000000);
    unlock();
    wr(IDX_CHIP_CTL, 8'h03);
    rd(IDX_CHIP_CTL, 32'h00000003);
    chk(iap_en_o, 1'b1);
    wr(8'h10, 8'h5A);
    rd(8'h10, 32'h00000000);
  endtask

  task automatic t_soft_reset;
    unlock();
    wr(IDX_CHIP_CTL, 8'h82);
    wait_core(1'b1);
    wait_core(1'b0);
    chk(boot_loader_o, 1'b1);
    chk(ram_retained_o, 1'b1);
    chk(data_ptr_o, 16'h0000);
    rd(IDX_CHIP_CTL, 32'h00000002);
  endtask

  task automatic t_hw_reset;
    hw_rst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    hw_rst_i <= 1'b0;
    wait_core(1'b0);
    chk(boot_loader_o, 1'b0);
    chk(ram_retained_o, 1'b1);
    rd(IDX_CHIP_CTL, 32'h00000000);
  endtask

  // Cold restart in mid-run with the configuration bit selecting the loader
  task automatic t_cold_reset;
    boot_cfg_i <= 8'h7F;
    rst_n_i    <= 1'b0;
    por_i      <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    por_i   <= 1'b0;
    wait_core(1'b0);
    chk(boot_loader_o, 1'b1);
    chk(ram_retained_o, 1'b0);
    chk(data_ptr_o, 16'h0000);
    rd(IDX_CHIP_CTL, 32'h00000002);
  endtask

  initial begin
    rst_n_i = 1'b0;
    por_i = 1'b1;
    hw_rst_i = 1'b0;
    boot_cfg_i = 8'hFF;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    por_i <= 1'b0;
    wait_core(1'b0);
    t_reset_vals();
    t_pointers();
    t_chip_ctl();
    t_soft_reset();
    t_hw_reset();
    t_cold_reset();
    close_out();
  end
endmodule // tb_top
